// ==== logic/tkc_pkg.sv ====
package tkc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES_DEF = TICK_NS * CLK_MHZ / 1000;
  localparam int ACQ_NS = 2000;
  localparam int ACQ_CYCLES_DEF = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 17;

  // ****************************************
  // register word indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_ADC_CTRL = 6'h00;
  localparam logic [5:0] IDX_KEY_CTRL = 6'h01;
  localparam logic [5:0] IDX_KEY_PEND = 6'h02;
  localparam logic [5:0] IDX_KEY_STAT = 6'h03;
  localparam logic [5:0] IDX_KEY_MASK = 6'h04;
  localparam logic [5:0] IDX_SCAN_STAT = 6'h05;
  localparam logic [5:0] IDX_GPIO_CTRL = 6'h0E;
  localparam logic [5:0] IDX_GPIO_DATA = 6'h0F;
  localparam logic [5:0] IDX_GPIO_PUD = 6'h10;
  localparam logic [5:0] IDX_RES_BASE = 6'h11;
  localparam logic [5:0] IDX_RES_LAST = 6'h1A;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int ADC_AUTO_BIT = 15;
  localparam int ADC_STS_BIT = 14;
  localparam int ADC_FN_LSB = 10;
  localparam int ADC_SET_LSB = 7;
  localparam logic [15:0] ADC_CTRL_WMASK = 16'hFF80;
  localparam logic [15:0] ADC_CTRL_RST = 16'h0000;
  localparam int KEY_MODE_LSB = 14;
  localparam int KEY_DBN_LSB = 11;
  localparam int KEY_START_BIT = 10;
  localparam logic [15:0] KEY_CTRL_WMASK = 16'hF800;
  localparam logic [15:0] KEY_CTRL_RST = 16'h0000;
  localparam logic [1:0] KM_HOST = 2'h0;
  localparam logic [1:0] KM_AUTO = 2'h2;
  localparam int GPIO_DATA_LSB = 8;
  localparam int NUM_RES = 10;

  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_XY = 4'h1;
  localparam logic [3:0] FN_XYZ = 4'h2;
  localparam logic [3:0] FN_X = 4'h3;
  localparam logic [3:0] FN_BAT = 4'h4;

  typedef enum logic [3:0] {
    CH_X = 4'h0, CH_Y = 4'h1, CH_Z1 = 4'h2, CH_Z2 = 4'h3,
    CH_CELL1 = 4'h4, CH_CELL2 = 4'h5, CH_SPARE1 = 4'h6, CH_SPARE2 = 4'h7,
    CH_TEMP1 = 4'h8, CH_TEMP2 = 4'h9
  } tkc_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SETTLE = 2'b01, ST_ACQ = 2'b10, ST_CONV = 2'b11
  } tkc_scan_t;

  typedef enum logic [0:0] {
    KS_IDLE = 1'b0, KS_SCAN = 1'b1
  } tkc_key_t;

  function automatic logic [2:0] seqLen(input logic [3:0] fn);
    case (fn)
      FN_XY: seqLen = 3'h2;
      FN_XYZ: seqLen = 3'h4;
      FN_X: seqLen = 3'h1;
      FN_BAT: seqLen = 3'h6;
      default: seqLen = 3'h1;
    endcase
  endfunction : seqLen

  function automatic tkc_chan_t seqChan(input logic [3:0] fn, input logic [2:0] step);
    if (fn == FN_BAT) seqChan = tkc_chan_t'(4'(step) + 4'h4);
    else seqChan = tkc_chan_t'({2'b00, step[1:0]});
  endfunction : seqChan

  // settling delay in timebase ticks of 1 us, 0 to 100 ms
  function automatic logic [TMR_W-1:0] settleTicks(input logic [2:0] sel);
    case (sel)
      3'h0: settleTicks = 17'h00000;
      3'h1: settleTicks = 17'h0000A;
      3'h2: settleTicks = 17'h00032;
      3'h3: settleTicks = 17'h00064;
      3'h4: settleTicks = 17'h003E8;
      3'h5: settleTicks = 17'h02710;
      3'h6: settleTicks = 17'h0C350;
      default: settleTicks = 17'h186A0;
    endcase
  endfunction : settleTicks

  // debounce period in ticks of 1 us, 2 ms to 70 ms
  function automatic logic [TMR_W-1:0] debounceTicks(input logic [2:0] sel);
    case (sel)
      3'h0: debounceTicks = 17'h007D0;
      3'h1: debounceTicks = 17'h02710;
      3'h2: debounceTicks = 17'h04E20;
      3'h3: debounceTicks = 17'h07530;
      3'h4: debounceTicks = 17'h09C40;
      3'h5: debounceTicks = 17'h0C350;
      3'h6: debounceTicks = 17'h0EA60;
      default: debounceTicks = 17'h11170;
    endcase
  endfunction : debounceTicks

endpackage : tkc_pkg

// ==== logic/tkc_scan_control.sv ====
`timescale 1ns/10ps
module tkc_scan_control #(
  parameter int TICK_CYCLES = tkc_pkg::TICK_CYCLES_DEF,
  parameter int ACQ_CYCLES = tkc_pkg::ACQ_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic touchPresent,
  output logic touchDriveOn,
  output logic batDividerOn,
  output logic tempBiasOn,
  output logic adcStart,
  output tkc_pkg::tkc_chan_t adcChannel,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic touchInterrupt_b,
  output logic keypadInterrupt_b,
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOe
);
  import tkc_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || ACQ_CYCLES < 1 || ACQ_CYCLES > 65535) begin : g_paramCheck
    $error("tkc_scan_control: timing parameter out of range");
  end

  // ****************************************
  // bus slave
  // ****************************************
  logic ack_q;
  logic busWr;
  logic [5:0] idx;
  logic [15:0] wrMask;
  logic [15:0] wd;
  logic [15:0] rdMux;
  logic [15:0] adcCtrl_q;
  logic [15:0] keyCtrl_q;
  logic [15:0] keyMask_q;
  logic [15:0] gpioCtrl_q;
  logic [7:0] gpioPud_q;
  logic [7:0] gpioOut_q;
  logic [15:0] pending_q;
  logic [15:0] res_q [NUM_RES];
  tkc_scan_t scanSt_q;
  tkc_key_t keySt_q;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction : merge

  assign idx = avsAddress[7:2];
  assign wd = avsWritedata[15:0];
  assign wrMask = {{8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
  // one wait state: the answer is always the second cycle of a request
  assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;
  assign busWr = avsWrite & ack_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ack_q <= 1'b0;
    else ack_q <= (avsRead | avsWrite) & ~ack_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) avsReaddata <= 32'h00000000;
    else if (avsRead & ~ack_q) avsReaddata <= {16'h0000, rdMux};
  end

  always_comb begin
    rdMux = 16'h0000;
    case (idx)
      IDX_ADC_CTRL: rdMux = adcCtrl_q;
      IDX_KEY_CTRL: rdMux = keyCtrl_q;
      IDX_KEY_PEND: rdMux = pending_q;
      IDX_KEY_STAT: rdMux = pending_q & ~keyMask_q;
      IDX_KEY_MASK: rdMux = keyMask_q;
      IDX_SCAN_STAT: rdMux = {13'h0000, touchPresent, keySt_q == KS_SCAN, scanSt_q != ST_IDLE};
      IDX_GPIO_CTRL: rdMux = gpioCtrl_q;
      IDX_GPIO_DATA: rdMux = {padIn, 8'h00};
      IDX_GPIO_PUD: rdMux = {gpioPud_q, 8'h00};
      default: begin
        if (idx >= IDX_RES_BASE && idx <= IDX_RES_LAST) rdMux = res_q[4'(idx - IDX_RES_BASE)];
      end
    endcase
  end

  // ****************************************
  // control registers
  // ****************************************
  logic adcWrite;
  logic keyWrite;
  logic [15:0] adcNew;
  logic [7:0] gpioSel;
  logic [7:0] gpioDir;
  logic [7:0] outMask;
  logic [7:0] dataLane;

  assign adcWrite = busWr && idx == IDX_ADC_CTRL;
  assign keyWrite = busWr && idx == IDX_KEY_CTRL;
  assign adcNew = merge(adcCtrl_q, wd, wrMask) & ADC_CTRL_WMASK;
  assign gpioSel = gpioCtrl_q[15:8];
  assign gpioDir = gpioCtrl_q[7:0];
  assign outMask = gpioSel & gpioDir;
  assign dataLane = outMask & {8{avsByteenable[1]}};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adcCtrl_q <= ADC_CTRL_RST;
      keyCtrl_q <= KEY_CTRL_RST;
      keyMask_q <= 16'h0000;
      gpioCtrl_q <= 16'h0000;
      gpioPud_q <= 8'h00;
    end else if (busWr) begin
      case (idx)
        IDX_ADC_CTRL: adcCtrl_q <= adcNew;
        IDX_KEY_CTRL: keyCtrl_q <= merge(keyCtrl_q, wd, wrMask) & KEY_CTRL_WMASK;
        IDX_KEY_MASK: keyMask_q <= merge(keyMask_q, wd, wrMask);
        IDX_GPIO_CTRL: gpioCtrl_q <= merge(gpioCtrl_q, wd, wrMask);
        IDX_GPIO_PUD: if (avsByteenable[1]) gpioPud_q <= wd[15:8];
        default: ;
      endcase
    end
  end

  // inputs are not stored: a pin turned output later drives its old value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) gpioOut_q <= 8'h00;
    else if (busWr && idx == IDX_GPIO_DATA) gpioOut_q <= (wd[GPIO_DATA_LSB +: 8] & dataLane) | (gpioOut_q & ~dataLane);
  end

  // ****************************************
  // timebase
  // ****************************************
  logic [15:0] tickCnt_q;
  logic tick;

  assign tick = tickCnt_q == 16'(TICK_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tickCnt_q <= 16'h0000;
    else if (tick) tickCnt_q <= 16'h0000;
    else tickCnt_q <= tickCnt_q + 16'h0001;
  end

  // ****************************************
  // touch and measurement scan
  // ****************************************
  logic touchPrev_q;
  logic touchRise;
  logic autoMode;
  logic hostMode;
  logic hostStart;
  logic [3:0] fnCur;
  logic [3:0] fn_q;
  logic [2:0] step_q;
  logic [TMR_W-1:0] timer_q;
  logic [15:0] acqCnt_q;
  logic acqLast;
  logic touchPend_q;
  tkc_chan_t curChan;

  assign touchRise = touchPresent & ~touchPrev_q;
  assign autoMode = adcCtrl_q[ADC_AUTO_BIT] & ~adcCtrl_q[ADC_STS_BIT];
  assign hostMode = ~adcCtrl_q[ADC_AUTO_BIT] & ~adcCtrl_q[ADC_STS_BIT];
  assign fnCur = adcCtrl_q[ADC_FN_LSB +: 4];
  assign hostStart = adcWrite && adcNew[ADC_FN_LSB +: 4] != FN_NONE && scanSt_q == ST_IDLE;
  assign acqLast = acqCnt_q == 16'(ACQ_CYCLES - 1);
  assign curChan = seqChan(fn_q, step_q);
  assign adcChannel = curChan;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) touchPrev_q <= 1'b0;
    else touchPrev_q <= touchPresent;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scanSt_q <= ST_IDLE;
      fn_q <= FN_NONE;
      step_q <= 3'h0;
      timer_q <= '0;
      acqCnt_q <= 16'h0000;
    end else begin
      case (scanSt_q)
        ST_IDLE: begin
          if (hostStart) begin
            fn_q <= adcNew[ADC_FN_LSB +: 4];
            step_q <= 3'h0;
            acqCnt_q <= 16'h0000;
            scanSt_q <= ST_ACQ;
          end else if (touchRise && autoMode && fnCur != FN_NONE && fnCur != FN_BAT) begin
            fn_q <= fnCur;
            step_q <= 3'h0;
            timer_q <= '0;
            scanSt_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (timer_q >= settleTicks(adcCtrl_q[ADC_SET_LSB +: 3])) begin
            acqCnt_q <= 16'h0000;
            scanSt_q <= ST_ACQ;
          end else if (tick) timer_q <= timer_q + 17'h00001;
        end
        ST_ACQ: begin
          if (acqLast) scanSt_q <= ST_CONV;
          else acqCnt_q <= acqCnt_q + 16'h0001;
        end
        ST_CONV: begin
          if (adcDone) begin
            if (step_q == 3'(seqLen(fn_q) - 3'h1)) scanSt_q <= ST_IDLE;
            else begin
              step_q <= step_q + 3'h1;
              acqCnt_q <= 16'h0000;
              scanSt_q <= ST_ACQ;
            end
          end
        end
        default: scanSt_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) adcStart <= 1'b0;
    else adcStart <= scanSt_q == ST_ACQ && acqLast;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_RES; i++) res_q[i] <= 16'h0000;
    end else if (scanSt_q == ST_CONV && adcDone) res_q[curChan] <= {4'h0, adcData};
  end

  // sampling happens in acquisition; only the touch drive stays closed into conversion, divider and bias open
  assign touchDriveOn = (scanSt_q == ST_ACQ || scanSt_q == ST_CONV) && curChan <= CH_Z2;
  assign batDividerOn = scanSt_q == ST_ACQ && (curChan == CH_CELL1 || curChan == CH_CELL2);
  assign tempBiasOn = scanSt_q == ST_ACQ && (curChan == CH_TEMP1 || curChan == CH_TEMP2);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) touchPend_q <= 1'b0;
    else if (touchRise && hostMode) touchPend_q <= 1'b1;
    else if (adcWrite) touchPend_q <= 1'b0;
  end
  assign touchInterrupt_b = ~touchPend_q;

  // ****************************************
  // keypad
  // ****************************************
  logic [1:0] keyMode;
  logic keyAuto;
  logic keyHost;
  logic keyOn;
  logic [3:0] rowsNow;
  logic pressPrev_q;
  logic pressRise;
  logic keyStartCmd;
  logic [1:0] col_q;
  logic [15:0] snap_q;
  logic [15:0] last_q;
  logic [15:0] frameMasked;
  logic [TMR_W-1:0] keyTimer_q;
  logic keyDone;
  logic keyPend_q;

  function automatic logic [15:0] colMask(input logic [7:0] sel);
    for (int i = 0; i < 16; i++) colMask[i] = ~sel[4 + i / 4];
  endfunction : colMask

  assign keyMode = keyCtrl_q[KEY_MODE_LSB +: 2];
  assign keyAuto = keyMode == KM_AUTO;
  assign keyHost = keyMode == KM_HOST;
  assign keyOn = keyAuto | keyHost;
  // rows rely on outside pull-ups; a pressed key pulls its row low
  assign rowsNow = ~padIn[3:0] & ~gpioSel[3:0];
  assign pressRise = (|rowsNow) && !pressPrev_q && keySt_q == KS_IDLE && keyOn;
  assign keyStartCmd = keyWrite && avsByteenable[1] && wd[KEY_START_BIT] && keyOn && keySt_q == KS_IDLE;
  assign frameMasked = {rowsNow, snap_q[11:0]} & colMask(gpioSel);
  assign keyDone = keySt_q == KS_SCAN && tick && col_q == 2'h3 && frameMasked == last_q
    && keyTimer_q >= debounceTicks(keyCtrl_q[KEY_DBN_LSB +: 3]);

  // held high while scanning: a key still down when the scan ends gives no fresh edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pressPrev_q <= 1'b0;
    else pressPrev_q <= keySt_q == KS_SCAN || (|rowsNow);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keySt_q <= KS_IDLE;
      col_q <= 2'h0;
      snap_q <= 16'h0000;
      last_q <= 16'h0000;
      keyTimer_q <= '0;
    end else begin
      case (keySt_q)
        KS_IDLE: begin
          if ((pressRise && keyAuto) || keyStartCmd) begin
            col_q <= 2'h0;
            keyTimer_q <= '0;
            keySt_q <= KS_SCAN;
          end
        end
        KS_SCAN: begin
          if (tick) begin
            snap_q[{col_q, 2'b00} +: 4] <= rowsNow;
            col_q <= col_q + 2'h1;
            if (keyTimer_q != '1) keyTimer_q <= keyTimer_q + 17'h00001;
            if (col_q == 2'h3) begin
              if (frameMasked != last_q) begin
                last_q <= frameMasked;
                keyTimer_q <= '0;
              end else if (keyDone) keySt_q <= KS_IDLE;
            end
          end
        end
        default: keySt_q <= KS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pending_q <= 16'h0000;
    else if (keyDone) pending_q <= frameMasked;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) keyPend_q <= 1'b0;
    else if (pressRise && keyHost) keyPend_q <= 1'b1;
    else if (keyWrite) keyPend_q <= 1'b0;
  end
  assign keypadInterrupt_b = ~keyPend_q;

  // ****************************************
  // pads
  // ****************************************
  always_comb begin
    padOut = 8'h00;
    padOe = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (gpioSel[i]) begin
        if (gpioDir[i]) begin
          if (gpioPud_q[i]) padOe[i] = ~gpioOut_q[i];
          else begin
            padOut[i] = gpioOut_q[i];
            padOe[i] = 1'b1;
          end
        end
      end else if (i >= 4 && keyOn) begin
        padOe[i] = keySt_q == KS_IDLE || col_q == 2'(i - 4);
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [2:0] batCnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) batCnt_q <= 3'h0;
    else if (scanSt_q == ST_IDLE) batCnt_q <= 3'h0;
    else if (adcStart && fn_q == FN_BAT) batCnt_q <= batCnt_q + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_settle;
    scanSt_q == ST_SETTLE && timer_q < settleTicks(adcCtrl_q[ADC_SET_LSB +: 3]) |=> scanSt_q == ST_SETTLE;
  endproperty
  a_settle: assert property (p_settle) else $error("scan left settling early");
  property p_drive;
    adcStart && curChan <= CH_Z2 |-> touchDriveOn;
  endproperty
  a_drive: assert property (p_drive) else $error("touch drive off during conversion");
  property p_divider;
    scanSt_q == ST_CONV |-> !batDividerOn;
  endproperty
  a_divider: assert property (p_divider) else $error("divider on outside sampling");
  property p_bias;
    tempBiasOn |=> tempBiasOn || adcStart;
  endproperty
  a_bias: assert property (p_bias) else $error("bias dropped before acquisition end");
  property p_six;
    scanSt_q != ST_IDLE ##1 scanSt_q == ST_IDLE && fn_q == FN_BAT |-> batCnt_q == 3'h6;
  endproperty
  a_six: assert property (p_six) else $error("battery scan not six conversions");
  property p_result;
    scanSt_q == ST_CONV && adcDone |=> res_q[$past(curChan)] == {4'h0, $past(adcData)};
  endproperty
  a_result: assert property (p_result) else $error("result register not updated");
  property p_auto;
    scanSt_q == ST_IDLE && touchRise && autoMode && fnCur != FN_NONE && fnCur != FN_BAT && !hostStart
      |=> scanSt_q == ST_SETTLE && fn_q == $past(fnCur);
  endproperty
  a_auto: assert property (p_auto) else $error("touch did not start scan");
  property p_touchIrq;
    touchRise && hostMode |=> !touchInterrupt_b && scanSt_q == $past(scanSt_q);
  endproperty
  a_touchIrq: assert property (p_touchIrq) else $error("touch interrupt missing");
  property p_keyAuto;
    pressRise && keyAuto |=> keySt_q == KS_SCAN && keyTimer_q == '0;
  endproperty
  a_keyAuto: assert property (p_keyAuto) else $error("key press did not start scan");
  property p_keypad_interrupt_n;
    pressRise && keyHost |=> !keypadInterrupt_b;
  endproperty
  a_keypad_interrupt_n: assert property (p_keypad_interrupt_n) else $error("key interrupt missing");
  property p_keyDone;
    keyDone |=> keySt_q == KS_IDLE && pending_q == $past(frameMasked);
  endproperty
  a_keyDone: assert property (p_keyDone) else $error("debounce result not stored");
  property p_gpioIn;
    busWr && idx == IDX_GPIO_DATA |=> (gpioOut_q & ~$past(outMask)) == ($past(gpioOut_q) & ~$past(outMask));
  endproperty
  a_gpioIn: assert property (p_gpioIn) else $error("input pin data stored");

  c_batScan: cover property (scanSt_q == ST_CONV && adcDone && fn_q == FN_BAT && step_q == 3'h5);
  c_autoScan: cover property (scanSt_q == ST_SETTLE ##1 scanSt_q == ST_ACQ);
  c_keyDone: cover property (keyDone);
  c_hostIrq: cover property (!touchInterrupt_b ##1 hostStart);

endmodule : tkc_scan_control

// ==== verification/tkc_adc_model.sv ====
`timescale 1ns/10ps
// ****************************************
// conversion core stand-in: answers five cycles after each start
// ****************************************
module tkc_adc_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic adcStart,
  input wire logic [3:0] adcChannel,
  output logic adcDone,
  output logic [11:0] adcData
);
  logic [2:0] wait_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 3'h0;
      adcDone <= 1'b0;
      adcData <= 12'h000;
    end else begin
      adcDone <= (wait_q == 3'h1);
      if (adcStart) wait_q <= 3'h4;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      // data is only valid with done; elsewhere it toggles so stale values never pass
      adcData <= (wait_q == 3'h1) ? {8'hA5, adcChannel} : ~adcData;
    end
  end
endmodule : tkc_adc_model

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import tkc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, touchPresent = 1'b0;
  logic [7:0] avsAddress = 8'h00, padPull = 8'hFF;
  logic [31:0] avsWritedata = 32'h0, avsReaddata;
  logic avsWaitrequest, touchDriveOn, batDividerOn, tempBiasOn, adcStart, adcDone;
  logic touchInterrupt_b, keypadInterrupt_b;
  logic [11:0] adcData;
  logic [7:0] padIn, padOut, padOe;
  tkc_chan_t adcChannel;
  int fails = 0, cmp_count = 0, nStart = 0;
  logic [15:0] q;
  logic [15:0] keyDown = 16'h0000;
  // ****************************************
  // pins resolve from drive enables; rows pulled up outside
  // ****************************************
  // a held key ties its row to its column while that column is driven low
  always_comb begin
    padIn = (padOe & padOut) | (~padOe & padPull);
    for (int k = 0; k < 16; k++) begin
      if (keyDown[k] && padOe[4 + k / 4] && !padOut[4 + k / 4]) padIn[k % 4] = 1'b0;
    end
  end
  always #5 clk = ~clk;
  tkc_scan_control #(.TICK_CYCLES(2), .ACQ_CYCLES(3)) dut_u (.clk(clk), .rst_b(rst_b),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(4'h3), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .touchPresent(touchPresent), .touchDriveOn(touchDriveOn), .batDividerOn(batDividerOn),
    .tempBiasOn(tempBiasOn), .adcStart(adcStart), .adcChannel(adcChannel), .adcDone(adcDone),
    .adcData(adcData), .touchInterrupt_b(touchInterrupt_b), .keypadInterrupt_b(keypadInterrupt_b),
    .padIn(padIn), .padOut(padOut), .padOe(padOe));
  tkc_adc_model adc_u (.clk(clk), .rst_b(rst_b), .adcStart(adcStart), .adcChannel(adcChannel),
    .adcDone(adcDone), .adcData(adcData));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] d, output logic [15:0] r);
    int n;
    logic wt;
    n = 0;
    @(posedge clk);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {16'h0000, d};
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
      wt = avsWaitrequest;
      r = avsReaddata[15:0];
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) chk(0, 1);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus
  task automatic waitIdle(input int b);
    int n;
    n = 0;
    repeat (10) @(posedge clk);
    do begin
      bus(1'b0, IDX_SCAN_STAT, 16'h0000, q);
      n++;
    end while (q[b] !== 1'b0 && n < 3000);
  endtask : waitIdle
  // ****************************************
  // enables watched every cycle
  // ****************************************
  always @(negedge clk) begin
    if (rst_b && batDividerOn === 1'b1) chk(adcChannel inside {CH_CELL1, CH_CELL2}, 1);
    if (rst_b && tempBiasOn === 1'b1) chk({adcStart, adcChannel inside {CH_TEMP1, CH_TEMP2}}, 1);
    if (rst_b && adcStart === 1'b1) begin
      nStart++;
      chk(touchDriveOn, adcChannel < CH_CELL1);
    end
  end
  task automatic t_touch_host;
    bus(1'b0, 6'h3F, 16'h0000, q);
    chk(q, 0);
    touchPresent <= 1'b1;
    repeat (6) @(posedge clk);
    chk({touchInterrupt_b, 8'(nStart)}, 0);
    touchPresent <= 1'b0;
    bus(1'b1, IDX_ADC_CTRL, 16'h0400, q);
    waitIdle(0);
    chk({touchInterrupt_b, 8'(nStart)}, 9'h102);
  endtask : t_touch_host
  task automatic t_cells;
    nStart = 0;
    bus(1'b1, IDX_ADC_CTRL, 16'h1000, q);
    waitIdle(0);
    chk(nStart, 6);
    for (int c = 4; c < 10; c++) begin
      bus(1'b0, IDX_RES_BASE + 6'(c), 16'h0000, q);
      chk(q, {8'hA5, 4'(c)});
    end
  endtask : t_cells
  task automatic t_touch_auto;
    bus(1'b1, IDX_ADC_CTRL, 16'h8480, q);
    waitIdle(0);
    nStart = 0;
    touchPresent <= 1'b1;
    repeat (20) @(posedge clk);
    chk(nStart, 0);
    waitIdle(0);
    touchPresent <= 1'b0;
    chk(nStart, 2);
    bus(1'b0, IDX_RES_BASE + 6'h01, 16'h0000, q);
    chk(q, 16'h0A51);
  endtask : t_touch_auto
  task automatic t_keys;
    bus(1'b1, IDX_KEY_MASK, 16'h0020, q);
    keyDown <= 16'h0020;
    repeat (6) @(posedge clk);
    chk(keypadInterrupt_b, 0);
    bus(1'b1, IDX_KEY_CTRL, 16'h0400, q);
    repeat (3000) @(posedge clk);
    bus(1'b0, IDX_SCAN_STAT, 16'h0000, q);
    chk(q[1], 1);
    waitIdle(1);
    chk(q[1], 0);
    chk(keypadInterrupt_b, 1);
    bus(1'b0, IDX_KEY_PEND, 16'h0000, q);
    chk(q, 16'h0020);
    bus(1'b0, IDX_KEY_STAT, 16'h0000, q);
    chk(q, 16'h0000);
    keyDown <= 16'h0000;
    bus(1'b1, IDX_KEY_CTRL, 16'h8000, q);
    keyDown <= 16'h8000;
    repeat (20) @(posedge clk);
    bus(1'b0, IDX_SCAN_STAT, 16'h0000, q);
    chk({keypadInterrupt_b, q[1]}, 2'h3);
    waitIdle(1);
    bus(1'b0, IDX_KEY_PEND, 16'h0000, q);
    chk(q, 16'h8000);
    bus(1'b0, IDX_KEY_STAT, 16'h0000, q);
    chk(q, 16'h8000);
    keyDown <= 16'h0000;
    bus(1'b1, IDX_KEY_CTRL, 16'h0000, q);
  endtask : t_keys
  task automatic t_gpio;
    padPull[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk(keypadInterrupt_b, 0);
    padPull[0] <= 1'b1;
    bus(1'b1, IDX_GPIO_CTRL, 16'hC080, q);
    bus(1'b1, IDX_GPIO_DATA, 16'hC000, q);
    @(negedge clk);
    chk({padOe[7:6], padOut[7]}, 3'h5);
    bus(1'b0, IDX_GPIO_DATA, 16'h0000, q);
    chk(q & 16'h80FF, 16'h8000);
    bus(1'b1, IDX_GPIO_PUD, 16'h8000, q);
    @(negedge clk);
    chk(padOe[7], 0);
    bus(1'b1, IDX_GPIO_DATA, 16'h0000, q);
    @(negedge clk);
    chk({padOe[7], padOut[7]}, 2'h2);
  endtask : t_gpio
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_touch_host();
    t_cells();
    t_touch_auto();
    t_keys();
    t_gpio();
    end_of_test();
  end
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule : tb_top
